/* File: rtl/uart_status_map.svh */
`ifndef UART_STATUS_MAP_SVH
`define UART_STATUS_MAP_SVH

// Character width served by the transmit buffer and receive data register
`define DATA_W_DEFAULT  10
// Idle count field width and the idle character counter behind it
`define IDLE_CFG_W      3
`define IDLE_CNT_W      8
// Transmit buffer depth
`define TX_BUF_DEPTH    2

// Levels and reset values
`define LINE_MARK       1'b1
`define FLAG_RESET      1'b0
`define STAT_RESET      8'h00

// Sticky status flag positions, also the write-one-to-clear mask layout
`define STAT_N          8
`define STAT_OVERRUN    0
`define STAT_IDLE       1
`define STAT_EDGE       2
`define STAT_NOISE      3
`define STAT_FRAMING    4
`define STAT_PARITY     5
`define STAT_MATCH_ONE  6
`define STAT_MATCH_TWO  7

`endif

/* File: rtl/uart_status_pkg.sv */
`include "uart_status_map.svh"

package uart_status_pkg;

    typedef enum logic [1:0]
    {
        SRC_PIN      = 2'b00,
        SRC_LOOP     = 2'b01,
        SRC_ONE_WIRE = 2'b10
    } rx_source_t;

    typedef logic [`STAT_N-1:0] status_vec_t;

endpackage : uart_status_pkg

/* File: rtl/stream_if.sv */
interface stream_if #(
    parameter int W = 10
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface : stream_if

/* File: rtl/two_entry_buffer.sv */
module two_entry_buffer
    import uart_status_pkg::*;
#(
    parameter int WIDTH = `DATA_W_DEFAULT,
    parameter int DEPTH = `TX_BUF_DEPTH
)(
    input  wire logic clock_i,    // Module clock
    input  wire logic reset_n_i,  // Synchronous reset, active low
    stream_if.sink    in_s,       // Filling side
    stream_if.source  out_s       // Draining side
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
        begin : g_bad_cfg
            $error("two_entry_buffer: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [PW:0]      count_q;
    logic             push;
    logic             pop;

    assign in_s.ready  = (count_q != FULL_COUNT);
    assign out_s.valid = (count_q != '0);
    assign out_s.data  = mem_q[rd_q];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    always_ff @(posedge clock_i)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_s.data;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop)
            begin
                count_q <= count_q + 1'b1;
            end
            else if (pop && !push)
            begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule : two_entry_buffer

/* File: rtl/sticky_flags.sv */
module sticky_flags
    import uart_status_pkg::*;
#(
    parameter int N = `STAT_N
)(
    input  wire logic         clock_i,    // Module clock
    input  wire logic         reset_n_i,  // Synchronous reset, active low
    input  wire logic [N-1:0] set_i,      // Hardware set, one per flag
    input  wire logic [N-1:0] clear_i,    // Software clear, one per flag
    output logic      [N-1:0] flag_o      // Flag state
);

    generate
        if (N < 1)
        begin : g_bad_cfg
            $error("sticky_flags: N must be at least 1");
        end
    endgenerate

    // Set beats clear so an event in the clearing cycle survives
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            flag_o <= '0;
        end
        else
        begin
            flag_o <= set_i | (flag_o & ~clear_i);
        end
    end

endmodule : sticky_flags

/* File: rtl/uart_status_top.sv */
// How it works
// - Loop mode feeds transmitter output to receiver, receive pin ignored.
// - With wrap enabled, source select 0 means loop, 1 means single-wire.
// - Single-wire is half-duplex: receiver sees the transmit pin, never the transmitter directly.
// - Single-wire, direction clear: transmit pin released, external party drives receiver.
// - Single-wire, direction set: pin driven, own characters not received.
// - Buffer-empty flag shows room; interrupt while flag and enable set.
// - Done flag when all sent and line idle; interrupt when enabled.
// - Transmit flags update regardless of interrupt enables, allowing polling.
// - Reading the data register clears the receive-full flag.
// - Idle flag clears only by writing one to its bit.
// - After setting, idle waits for a new received character before setting again.
// - Noise, framing, parity flags set together with receive-full.
// - No error flags for a character lost to overrun.
// - Receive-full still set on new character: overrun, character dropped.
// - Match hits set together with receive-full on equal character.
// - Active edge on the receive input sets the edge flag while the receiver is enabled.
// - Edge flag clears only by writing one to it.
// - Edge detection only while the receiver is enabled.
// - Idle line declared after the programmed count of idle characters.
module uart_status_top
    import uart_status_pkg::*;
#(
    parameter int DATA_W = `DATA_W_DEFAULT
)(
    input  wire logic                   clock_i,                     // 250 MHz clock
    input  wire logic                   reset_n_i,                   // Sync reset, low
    input  wire logic                   internal_wrap_enable_i,      // Loop or one-wire
    input  wire logic                   rx_source_select_i,          // 0 loop, 1 one-wire
    input  wire logic                   one_wire_drive_direction_i,  // 1 drive pin
    input  wire logic                   rx_enable_i,                 // Receiver enable
    input  wire logic                   tx_empty_irq_enable_i,       // Empty irq enable
    input  wire logic                   tx_done_irq_enable_i,        // Done irq enable
    input  wire logic [`IDLE_CFG_W-1:0] idle_count_field_i,          // Idle chars, log2
    input  wire logic [DATA_W-1:0]      match_value_one_i,           // First match
    input  wire logic [DATA_W-1:0]      match_value_two_i,           // Second match
    input  wire logic                   serial_in_pin_i,             // Receive pin
    input  wire logic                   serial_out_pin_i,            // Transmit pin level
    output logic                        serial_out_pin_o,            // Transmit pin drive
    output logic                        serial_out_pin_oe_o,         // High while driving
    input  wire logic                   tx_serial_i,                 // Transmitter output
    input  wire logic                   tx_busy_i,                   // Shifter active
    input  wire logic                   tx_write_i,                  // Software write
    input  wire logic [DATA_W-1:0]      tx_write_data_i,             // Written character
    output logic                        tx_write_ready_o,            // Buffer has room
    output logic                        tx_load_valid_o,             // Character for shifter
    output logic      [DATA_W-1:0]      tx_load_data_o,              // Character data
    input  wire logic                   tx_load_ready_i,             // Shifter takes it
    output logic                        rx_serial_o,                 // Selected rx line
    input  wire logic                   rx_char_valid_i,             // Shifter has char
    input  wire logic [DATA_W-1:0]      rx_char_data_i,              // Received char
    input  wire logic                   rx_noise_i,                  // Char had noise
    input  wire logic                   rx_frame_err_i,              // Char framing error
    input  wire logic                   rx_parity_err_i,             // Char parity error
    input  wire logic                   rx_idle_char_i,              // Idle char seen
    input  wire logic                   data_read_i,                 // Data register read
    output logic      [DATA_W-1:0]      rx_data_o,                   // Data register
    input  wire logic                   status_write_i,              // Status write
    input  wire logic [`STAT_N-1:0]     status_clear_i,              // Ones clear flags
    output logic                        tx_buffer_empty_flag_o,      // Room in buffer
    output logic                        tx_done_flag_o,              // All sent, idle
    output logic                        tx_empty_irq_o,              // Empty request
    output logic                        tx_done_irq_o,               // Done request
    output logic                        rx_buffer_full_flag_o,       // Data waiting
    output logic                        overrun_flag_o,              // Char lost
    output logic                        idle_line_flag_o,            // Idle line
    output logic                        rx_edge_flag_o,              // Active edge
    output logic                        noise_flag_o,                // Noise
    output logic                        framing_error_flag_o,        // Framing error
    output logic                        parity_error_flag_o,         // Parity error
    output logic                        match_one_hit_flag_o,        // First match hit
    output logic                        match_two_hit_flag_o         // Second match hit
);

    generate
        if (DATA_W < 1 || DATA_W > 16)
        begin : g_bad_cfg
            $error("uart_status_top: DATA_W must lie in 1..16");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////
    // Receive source and transmit pin

    rx_source_t source_mode;
    logic       rx_line_d;
    logic       rx_line_q;
    logic       rx_line_prev_q;

    always_comb
    begin
        if (!internal_wrap_enable_i)
        begin
            source_mode = SRC_PIN;
        end
        else if (rx_source_select_i)
        begin
            source_mode = SRC_ONE_WIRE;
        end
        else
        begin
            source_mode = SRC_LOOP;
        end
    end

    always_comb
    begin
        case (source_mode)
            SRC_LOOP:
            begin
                rx_line_d = tx_serial_i;
            end
            SRC_ONE_WIRE:
            begin
                rx_line_d = one_wire_drive_direction_i ? `LINE_MARK : serial_out_pin_i;
            end
            SRC_PIN:
            begin
                rx_line_d = serial_in_pin_i;
            end
            default:
            begin
                rx_line_d = `LINE_MARK;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            rx_line_q      <= `LINE_MARK;
            rx_line_prev_q <= `LINE_MARK;
        end
        else
        begin
            rx_line_q      <= rx_line_d;
            rx_line_prev_q <= rx_line_q;
        end
    end

    assign rx_serial_o = rx_line_q;

    // pin released while listening on one wire
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            serial_out_pin_o    <= `LINE_MARK;
            serial_out_pin_oe_o <= 1'b0;
        end
        else
        begin
            serial_out_pin_o    <= tx_serial_i;
            serial_out_pin_oe_o <= !(source_mode == SRC_ONE_WIRE) || one_wire_drive_direction_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Transmit buffer and transmit flags

    stream_if #(.W(DATA_W)) tx_in_s ();
    stream_if #(.W(DATA_W)) tx_out_s ();

    assign tx_in_s.valid   = tx_write_i;
    assign tx_in_s.data    = tx_write_data_i;
    assign tx_out_s.ready  = tx_load_ready_i;
    assign tx_load_valid_o = tx_out_s.valid;
    assign tx_load_data_o  = tx_out_s.data;

    two_entry_buffer #(
        .WIDTH (DATA_W),
        .DEPTH (`TX_BUF_DEPTH)
    ) u_tx_buffer (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .in_s      (tx_in_s),
        .out_s     (tx_out_s)
    );

    // empty flag is buffer room, independent of enable
    assign tx_buffer_empty_flag_o = tx_in_s.ready;
    assign tx_write_ready_o       = tx_in_s.ready;

    // done once nothing queued, shifter idle, line at mark
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            tx_done_flag_o <= `FLAG_RESET;
        end
        else
        begin
            tx_done_flag_o <= !tx_out_s.valid && !tx_busy_i && (tx_serial_i == `LINE_MARK);
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            tx_empty_irq_o <= 1'b0;
            tx_done_irq_o  <= 1'b0;
        end
        else
        begin
            tx_empty_irq_o <= tx_in_s.ready && tx_empty_irq_enable_i;
            tx_done_irq_o  <= tx_done_flag_o && tx_done_irq_enable_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Receive data register

    logic rx_accept;
    logic rx_overrun;

    // a read in the same cycle frees the register in time
    assign rx_accept  = rx_char_valid_i && (!rx_buffer_full_flag_o || data_read_i);
    assign rx_overrun = rx_char_valid_i && rx_buffer_full_flag_o && !data_read_i;

    // read clears full, new character wins
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            rx_buffer_full_flag_o <= `FLAG_RESET;
            rx_data_o             <= '0;
        end
        else if (rx_accept)
        begin
            rx_buffer_full_flag_o <= 1'b1;
            rx_data_o             <= rx_char_data_i;
        end
        else if (data_read_i)
        begin
            rx_buffer_full_flag_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Idle line detection

    logic                   idle_armed_q;
    logic [`IDLE_CNT_W-1:0] idle_count_q;
    logic [`IDLE_CNT_W-1:0] idle_target;
    logic                   idle_set;

    // Count of 2**field idle characters; field 0 means a single one
    assign idle_target = `IDLE_CNT_W'(1) << idle_count_field_i;
    assign idle_set    = idle_armed_q && rx_idle_char_i && (idle_count_q + 1'b1 >= idle_target);

    // rearm only from a character that set receive-full
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            idle_armed_q <= 1'b0;
            idle_count_q <= '0;
        end
        else if (rx_accept)
        begin
            idle_armed_q <= 1'b1;
            idle_count_q <= '0;
        end
        else if (idle_set)
        begin
            idle_armed_q <= 1'b0;
            idle_count_q <= '0;
        end
        else if (rx_idle_char_i && idle_armed_q)
        begin
            idle_count_q <= idle_count_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Sticky status flags

    status_vec_t stat_set;
    status_vec_t stat_clear;
    status_vec_t stat_q;
    logic        edge_seen;

    // falling edge opens a start bit, only when enabled
    assign edge_seen = rx_enable_i && rx_line_prev_q && !rx_line_q;

    always_comb
    begin
        stat_set                  = '0;
        stat_set[`STAT_OVERRUN]   = rx_overrun;
        stat_set[`STAT_IDLE]      = idle_set;
        stat_set[`STAT_EDGE]      = edge_seen;
        // errors only with an accepted character
        stat_set[`STAT_NOISE]     = rx_accept && rx_noise_i;
        stat_set[`STAT_FRAMING]   = rx_accept && rx_frame_err_i;
        stat_set[`STAT_PARITY]    = rx_accept && rx_parity_err_i;
        stat_set[`STAT_MATCH_ONE] = rx_accept && (rx_char_data_i == match_value_one_i);
        stat_set[`STAT_MATCH_TWO] = rx_accept && (rx_char_data_i == match_value_two_i);
    end

    assign stat_clear = status_write_i ? status_clear_i : '0;

    sticky_flags #(
        .N (`STAT_N)
    ) u_flags (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .set_i     (stat_set),
        .clear_i   (stat_clear),
        .flag_o    (stat_q)
    );

    assign overrun_flag_o       = stat_q[`STAT_OVERRUN];
    assign idle_line_flag_o     = stat_q[`STAT_IDLE];
    assign rx_edge_flag_o       = stat_q[`STAT_EDGE];
    assign noise_flag_o         = stat_q[`STAT_NOISE];
    assign framing_error_flag_o = stat_q[`STAT_FRAMING];
    assign parity_error_flag_o  = stat_q[`STAT_PARITY];
    assign match_one_hit_flag_o = stat_q[`STAT_MATCH_ONE];
    assign match_two_hit_flag_o = stat_q[`STAT_MATCH_TWO];

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    a_loop_feeds_rx: assert property (
        internal_wrap_enable_i && !rx_source_select_i |=> rx_serial_o == $past(tx_serial_i))
        else $error("loop mode did not feed transmitter to receiver");
    a_listen_releases_pin: assert property (
        internal_wrap_enable_i && rx_source_select_i && !one_wire_drive_direction_i
        |=> !serial_out_pin_oe_o && rx_serial_o == $past(serial_out_pin_i))
        else $error("one-wire listen did not release pin");
    a_drive_breaks_loop: assert property (
        internal_wrap_enable_i && rx_source_select_i && one_wire_drive_direction_i
        |=> serial_out_pin_oe_o && rx_serial_o)
        else $error("one-wire drive still internal_wrap_enable own characters");
    a_empty_irq_follows: assert property (
        tx_empty_irq_enable_i && tx_buffer_empty_flag_o |=> tx_empty_irq_o)
        else $error("empty interrupt missing");
    a_read_clears_full: assert property (
        data_read_i && !rx_char_valid_i |=> !rx_buffer_full_flag_o)
        else $error("read did not clear receive-full");
    a_idle_needs_char: assert property (
        $rose(idle_line_flag_o) |-> $past(idle_armed_q) && !idle_armed_q)
        else $error("idle set without a new character");
    a_error_with_full: assert property (
        rx_char_valid_i && !rx_buffer_full_flag_o && rx_frame_err_i
        |=> framing_error_flag_o && rx_buffer_full_flag_o)
        else $error("framing error not set with receive-full");
    a_overrun_drops_char: assert property (
        rx_overrun && !status_write_i
        |=> overrun_flag_o && $stable(rx_data_o) && $stable(parity_error_flag_o))
        else $error("overrun character not discarded");
    a_match_with_full: assert property (
        rx_accept && rx_char_data_i == match_value_two_i
        |=> match_two_hit_flag_o && rx_buffer_full_flag_o)
        else $error("match hit not set with receive-full");
    a_edge_needs_enable: assert property (
        !rx_enable_i && !rx_edge_flag_o |=> !rx_edge_flag_o)
        else $error("edge flag set with receiver disabled");
    a_edge_sets_flag: assert property (
        rx_serial_o ##1 (rx_enable_i && !rx_serial_o) |=> rx_edge_flag_o)
        else $error("active edge not flagged");

    c_loop_mode: cover property (internal_wrap_enable_i && !rx_source_select_i ##1 edge_seen);
    c_one_wire_rx: cover property (source_mode == SRC_ONE_WIRE ##2 rx_accept);
    c_overrun: cover property (rx_overrun);
    c_idle_rise: cover property ($rose(idle_line_flag_o));

endmodule : uart_status_top

/* File: tb/serial_peer.sv */
// Far-side peer: idles at mark, sends a low start pulse on request
module serial_peer (
    input  wire logic clock_i,   // Module clock
    input  wire logic send_i,    // Start a low pulse
    output logic      line_o     // Peer line level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt_q = 3'h0;
    always_ff @(posedge clock_i)
    begin
        if (send_i)
            cnt_q <= 3'h4;
        else if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
    end
    // Idle line rests at mark, so a released line reads high
    assign line_o = (cnt_q == 3'h0);
endmodule : serial_peer

/* File: tb/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 0, reset_n_i = 0, internal_wrap_enable_i = 0, rx_source_select_i = 0;
    logic one_wire_drive_direction_i = 0, rx_enable_i = 0, tx_empty_irq_enable_i = 0;
    logic tx_done_irq_enable_i = 0, serial_in_pin_i, serial_out_pin_i, serial_out_pin_o;
    logic serial_out_pin_oe_o, tx_serial_i = 1, tx_busy_i = 0, tx_write_i = 0;
    logic tx_write_ready_o, tx_load_valid_o, tx_load_ready_i = 0, rx_serial_o;
    logic rx_char_valid_i = 0, rx_noise_i = 0, rx_frame_err_i = 0, rx_parity_err_i = 0;
    logic rx_idle_char_i = 0, data_read_i = 0, status_write_i = 0, tx_buffer_empty_flag_o;
    logic tx_done_flag_o, tx_empty_irq_o, tx_done_irq_o, rx_buffer_full_flag_o;
    logic overrun_flag_o, idle_line_flag_o, rx_edge_flag_o, noise_flag_o, send = 0;
    logic framing_error_flag_o, parity_error_flag_o, match_one_hit_flag_o, match_two_hit_flag_o;
    logic [2:0] idle_count_field_i = 3'h0;
    logic [7:0] status_clear_i = 8'h00;
    logic [9:0] match_value_one_i = 10'h055, match_value_two_i = 10'h0aa;
    logic [9:0] tx_write_data_i = 10'h000, tx_load_data_o, rx_char_data_i = 10'h000, rx_data_o;
    int num_errors = 0, checks_done = 0;
    always #2 clock_i = ~clock_i;
    serial_peer i_peer (.clock_i(clock_i), .send_i(send), .line_o(serial_in_pin_i));
    // Released one-wire pin follows the peer
    assign serial_out_pin_i = serial_out_pin_oe_o ? serial_out_pin_o : serial_in_pin_i;
    uart_status_top i_dut (.*);
    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(negedge clock_i);
    endtask : step
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        s = 1;
        step(1);
        s = 0;
        step(1);
    endtask : pulse
    task automatic rxc(input logic [9:0] d, input logic [2:0] e);
        rx_char_data_i = d;
        {rx_noise_i, rx_frame_err_i, rx_parity_err_i} = e;
        pulse(rx_char_valid_i);
    endtask : rxc
    task automatic clr(input logic [7:0] m);
        status_clear_i = m;
        pulse(status_write_i);
    endtask : clr
    task automatic summarize;
        $display("checks=%0d mismatches=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    // Hang guard at 25000 cycles, far beyond the length of the test
    initial
    begin
        #100000;
        num_errors++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        step(4);
        reset_n_i = 1;
        step(2);
        chk(tx_buffer_empty_flag_o, 1);
        // Loop: receiver follows transmitter, pin stays driven
        {internal_wrap_enable_i, tx_serial_i} = 2'b10;
        step(2);
        chk(rx_serial_o, 0);
        chk(serial_out_pin_oe_o, 1);
        // One-wire, pin released, peer drives
        // Transmitter at mark, so a low receive line can only come from the peer
        {rx_source_select_i, send, tx_serial_i} = 3'b111;
        step(1);
        send = 0;
        step(1);
        chk(serial_out_pin_oe_o, 0);
        chk(rx_serial_o, 0);
        step(4);
        // Transmitter low, so a high receive line shows the loop is broken
        {one_wire_drive_direction_i, tx_serial_i} = 2'b10;
        step(2);
        chk({serial_out_pin_oe_o, serial_out_pin_o}, 2'b10);
        chk(rx_serial_o, 1);
        {internal_wrap_enable_i, rx_source_select_i, tx_serial_i} = 3'b001;
        $display("test modes done");
        tx_write_data_i = 10'h123;
        tx_write_i = 1;
        step(1);
        tx_write_data_i = 10'h2c4;
        pulse(tx_write_i);
        chk({tx_buffer_empty_flag_o, tx_write_ready_o}, 2'b00);
        chk({tx_load_valid_o, tx_load_data_o}, {1'b1, 10'h123});
        chk(tx_done_flag_o, 0);
        tx_load_ready_i = 1;
        step(1);
        chk(tx_load_data_o, 10'h2c4);
        chk(tx_buffer_empty_flag_o, 1);
        step(2);
        tx_load_ready_i = 0;
        chk({tx_load_valid_o, tx_done_flag_o}, 2'b01);
        {tx_empty_irq_enable_i, tx_done_irq_enable_i} = 2'b11;
        step(2);
        chk({tx_empty_irq_o, tx_done_irq_o}, 2'b11);
        // A busy shifter means the transmitter is not done
        tx_busy_i = 1;
        step(2);
        chk(tx_done_flag_o, 0);
        tx_busy_i = 0;
        $display("test transmit done");
        rxc(10'h055, 3'b100);
        chk({rx_buffer_full_flag_o, noise_flag_o, match_one_hit_flag_o}, 3'b111);
        chk({framing_error_flag_o, match_two_hit_flag_o}, 2'b00);
        rxc(10'h0aa, 3'b011);
        chk({overrun_flag_o, framing_error_flag_o, parity_error_flag_o}, 3'b100);
        chk({rx_data_o, match_two_hit_flag_o}, {10'h055, 1'b0});
        pulse(data_read_i);
        chk(rx_buffer_full_flag_o, 0);
        clr(8'hff);
        chk({overrun_flag_o, noise_flag_o, match_one_hit_flag_o}, 3'b000);
        $display("test receive done");
        idle_count_field_i = 3'h1;
        pulse(rx_idle_char_i);
        chk(idle_line_flag_o, 0);
        pulse(rx_idle_char_i);
        chk(idle_line_flag_o, 1);
        clr(8'h01);
        chk(idle_line_flag_o, 1);
        clr(8'h02);
        repeat (4) pulse(rx_idle_char_i);
        chk(idle_line_flag_o, 0);
        rxc(10'h001, 3'b000);
        repeat (2) pulse(rx_idle_char_i);
        chk(idle_line_flag_o, 1);
        $display("test idle done");
        pulse(send);
        step(4);
        chk(rx_edge_flag_o, 0);
        rx_enable_i = 1;
        pulse(send);
        step(1);
        chk(rx_edge_flag_o, 1);
        clr(8'hfb);
        chk(rx_edge_flag_o, 1);
        clr(8'h04);
        chk(rx_edge_flag_o, 0);
        $display("test edge done");
        summarize();
    end
endmodule : tb_top
